/* File: src/bfs_supervisor.sv */
/*
 * Mode, limit and fault supervision for a USB-fed step-down converter.
 * Assumes comparator and configuration inputs are synchronous to sys_clk_in.
 */
`timescale 1ns/1ps
module bfs_supervisor
    import bfs_pkg::*;
#(
    parameter int unsigned ILIM_CYC = BFS_ILIM_CYC,
    parameter int unsigned RETRY_CYC_DEFAULT = BFS_RETRY_CYC
)
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic startup_load_in,
    input wire logic serial_variant_in,
    input wire logic freq_lock_is_input_in,
    input wire logic freq_lock_level_in,
    input wire logic ext_clock_active_in,
    input wire logic dedicated_charging_port_mode_in,
    input wire logic dcp_attach_in,
    input wire logic sense_attach_in,
    input wire logic first_config_resistor_ss_in,
    input wire logic [3:0] second_config_resistor_in,
    input wire logic [2:0] third_config_resistor_in,
    input wire logic [2:0] serial_current_limit_select_in,
    input wire logic [4:0] serial_gain_in,
    input wire logic serial_ss_en_in,
    input wire logic serial_ss_en_wr_in,
    input wire logic limit_reset_trip_select_in,
    input wire logic [BFS_CNT_W-1:0] retry_cycles_in,
    input wire logic peak_limit_in,
    input wire logic load_limit_in,
    input wire logic switch_cycle_in,
    input wire logic output_uv_in,
    input wire logic output_below_2v_in,
    input wire logic short_gnd_in,
    input wire logic output_ov_in,
    input wire logic temp_over_165_in,
    input wire logic temp_below_155_in,
    input wire logic temp_over_140_in,
    input wire logic clear_flags_in,
    output logic forced_pwm_out,
    output logic dither_en_out,
    output logic high_side_en_out,
    output logic converter_en_out,
    output logic constant_current_out,
    output logic fault_pin_out,
    output logic bus_current_limit_flag_out,
    output logic short_flag_out,
    output logic overvoltage_flag_out,
    output logic thermal_warning_flag_out,
    output logic [2:0] current_limit_select_out,
    output logic [4:0] cable_gain_out
);
    bfs_state_e state_q;
    logic ss_en_q;
    logic [2:0] ilim_q;
    logic [4:0] gain_q;
    logic [1:0] peak_cnt_q;
    logic thermal_off_q;
    logic warn_prev_q;
    logic ilim_long;
    logic retry_done;
    logic peak_reset;
    logic fault_now;
    logic fault_active;
    logic [2:0] ilim_subset;
    logic fault_hold;
    logic ilim_trip;
    logic run_ok;
    logic [BFS_CNT_W-1:0] retry_limit;

    // Sustained load-limit timer
    bfs_timer u_ilim_timer
    (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .run_in(load_limit_in),
        .limit_in(BFS_CNT_W'(ILIM_CYC)),
        .done_out(ilim_long)
    );

    // Zero on the port selects the built-in delay
    assign retry_limit = (retry_cycles_in == '0) ? BFS_CNT_W'(RETRY_CYC_DEFAULT)
        : retry_cycles_in;

    // Retry delay after fault removal
    bfs_timer u_retry_timer
    (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .run_in(state_q == BFS_RETRY),
        .limit_in(retry_limit),
        .done_out(retry_done)
    );

    // Standalone limit subset: top bit forced high
    assign ilim_subset = {1'b1, third_config_resistor_in[1:0]};

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            ss_en_q <= 1'b0;
        else if (startup_load_in)
            ss_en_q <= first_config_resistor_ss_in;
        else if (serial_variant_in && serial_ss_en_wr_in)
            ss_en_q <= serial_ss_en_in;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            ilim_q <= BFS_ILIM_RST;
            gain_q <= BFS_GAIN_RST;
        end
        else if (serial_variant_in)
        begin
            ilim_q <= serial_current_limit_select_in;
            gain_q <= serial_gain_in;
        end
        else if (startup_load_in)
        begin
            ilim_q <= ilim_subset;
            gain_q <= {third_config_resistor_in[2], second_config_resistor_in};
        end
    end

    // Consecutive peak-limit switching cycles
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in || state_q != BFS_RUN)
            peak_cnt_q <= '0;
        else if (switch_cycle_in)
        begin
            if (peak_limit_in && output_below_2v_in)
                peak_cnt_q <= (peak_cnt_q == 2'h3) ? 2'h3 : peak_cnt_q + 2'h1;
            else
                peak_cnt_q <= '0;
        end
    end
    assign peak_reset = switch_cycle_in && peak_limit_in && output_below_2v_in
        && (peak_cnt_q == 2'(BFS_PEAK_CYCLES - 1));

    // Thermal hysteresis
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            thermal_off_q <= 1'b0;
        else if (temp_over_165_in)
            thermal_off_q <= 1'b1;
        else if (temp_below_155_in)
            thermal_off_q <= 1'b0;
    end

    assign fault_active = short_gnd_in || output_uv_in || output_ov_in;
    // Overheating also parks the stage and re-arms through the retry delay
    assign fault_hold = fault_active || thermal_off_q;
    assign ilim_trip = ilim_long && !limit_reset_trip_select_in && output_uv_in;
    assign fault_now = fault_hold || peak_reset || ilim_trip;
    assign run_ok = (state_q == BFS_RUN) && !fault_now;

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            state_q <= BFS_RUN;
        else
        begin
            case (state_q)
                BFS_RUN:
                    if (fault_now)
                        state_q <= BFS_FAULT;
                BFS_FAULT:
                    if (!fault_hold)
                        state_q <= BFS_RETRY;
                BFS_RETRY:
                    if (fault_hold)
                        state_q <= BFS_FAULT;
                    else if (retry_done)
                        state_q <= BFS_RUN;
                default:
                    state_q <= BFS_RUN;
            endcase
        end
    end

    // Crossing detector for the warning comparator
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            warn_prev_q <= 1'b0;
        else
            warn_prev_q <= temp_over_140_in;
    end

    // Sticky flags: set wins over clear
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            bus_current_limit_flag_out <= 1'b0;
        else if (ilim_long)
            bus_current_limit_flag_out <= 1'b1;
        else if (clear_flags_in)
            bus_current_limit_flag_out <= 1'b0;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            short_flag_out <= 1'b0;
        else if (short_gnd_in || output_uv_in)
            short_flag_out <= 1'b1;
        else if (clear_flags_in)
            short_flag_out <= 1'b0;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            overvoltage_flag_out <= 1'b0;
        else if (output_ov_in)
            overvoltage_flag_out <= 1'b1;
        else if (clear_flags_in)
            overvoltage_flag_out <= 1'b0;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            thermal_warning_flag_out <= 1'b0;
        else if (serial_variant_in && temp_over_140_in && !warn_prev_q)
            thermal_warning_flag_out <= 1'b1;
        else if (clear_flags_in)
            thermal_warning_flag_out <= 1'b0;
    end

    // Error pin follows live faults and the sustained limit
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            fault_pin_out <= 1'b0;
        else
            fault_pin_out <= ilim_long || fault_active;
    end

    // Stage enables
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            converter_en_out <= 1'b0;
            high_side_en_out <= 1'b0;
        end
        else
        begin
            converter_en_out <= run_ok;
            high_side_en_out <= run_ok && !peak_limit_in && !load_limit_in;
        end
    end

    // Skip only with lock input high, internal clock and charging mode
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            forced_pwm_out <= 1'b1;
        else if (freq_lock_is_input_in && freq_lock_level_in && !ext_clock_active_in
            && dedicated_charging_port_mode_in)
            forced_pwm_out <= dcp_attach_in || sense_attach_in;
        else
            forced_pwm_out <= 1'b1;
    end

    // Dither gated off by an external clock
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            dither_en_out <= 1'b0;
        else
            dither_en_out <= ss_en_q && !ext_clock_active_in;
    end

    // Constant-current regulation request
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            constant_current_out <= 1'b0;
        else
            constant_current_out <= load_limit_in;
    end

    // Limit and compensation settings to the analog side
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            current_limit_select_out <= BFS_ILIM_RST;
            cable_gain_out <= BFS_GAIN_RST;
        end
        else
        begin
            current_limit_select_out <= ilim_q;
            cable_gain_out <= gain_q;
        end
    end
endmodule : bfs_supervisor

/* File: src/bfs_pkg.sv */
/*
 * Constants, state encodings and timing counts for the converter fault supervisor.
 * Assumes a 40 MHz system clock and comparator inputs already synchronous to it.
 */
// Contract
// - Frequency-lock input high in 2.4A charging mode: PWM on attach, else skip.
// - Spread-spectrum enable loaded at startup from first config resistor; 6.8% span.
// - Dither only on internal oscillator; never with external clock.
// - Peak or load threshold exceeded: high-side off at once, start limit handling.
// - External limit over 16ms asserts error pin and bus current-limit flag.
// - Over programmed threshold the loop regulates constant current.
// - Trip-select clear: reset after 16ms limit plus output undervoltage.
// - Reset after four consecutive peak-limit cycles with output under 2.0V.
// - Short or undervoltage: reset, error pin, flag; retry soft-start after 2s.
// - Overvoltage: shut down, error pin, flag; off until clear then 2s.
// - Shut down above 165C; re-enable after cooling 10C.
// - Serial variants: thermal warning flag when die crosses 140C.
// - DC current limit from a 3-bit select of eight values.
// - Standalone: limit chosen from subset decoded from third config resistor.
// - Serial variants: cable compensation from a 5-bit field.
// - Standalone: compensation low four bits from second, top bit from third resistor.
// - After a fault clears, a configurable retry timer holds switching off.
package bfs_pkg;
    localparam int unsigned BFS_CLK_HZ = 40000000;
    localparam int unsigned BFS_ILIM_MS = 16;
    localparam int unsigned BFS_RETRY_S = 2;
    localparam int unsigned BFS_ILIM_CYC = BFS_CLK_HZ / 1000 * BFS_ILIM_MS;
    localparam int unsigned BFS_RETRY_CYC = BFS_CLK_HZ * BFS_RETRY_S;
    localparam int unsigned BFS_PEAK_CYCLES = 4;
    localparam int unsigned BFS_SS_SPAN_PERMILLE = 68;
    localparam int unsigned BFS_CNT_W = 32;
    localparam logic [2:0] BFS_ILIM_RST = 3'h7;
    localparam logic [4:0] BFS_GAIN_RST = 5'h00;

    typedef enum logic [1:0]
    {
        BFS_RUN = 2'b00,
        BFS_FAULT = 2'b01,
        BFS_RETRY = 2'b10
    } bfs_state_e;
endpackage : bfs_pkg

/* File: src/bfs_timer.sv */
/*
 * Cycle counter that reports when a running condition has lasted a limit.
 * Assumes a synchronous active-high reset.
 */
`timescale 1ns/1ps
module bfs_timer
    import bfs_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic run_in,
    input wire logic [BFS_CNT_W-1:0] limit_in,
    output logic done_out
);
    logic [BFS_CNT_W-1:0] count_q;

    // Counts while run is high, clears otherwise, saturates at limit
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in || !run_in)
            count_q <= '0;
        else if (count_q < limit_in)
            count_q <= count_q + 1'b1;
    end

    assign done_out = run_in && (count_q >= limit_in);
endmodule : bfs_timer

/* File: testbench/bfs_monitor.sv */
/* Port-level assertions for the fault supervisor.
 * Bound to bfs_supervisor; one clock, sync reset. */
`timescale 1ns/1ps
module bfs_monitor
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic freq_lock_is_input_in,
    input wire logic freq_lock_level_in,
    input wire logic ext_clock_active_in,
    input wire logic dedicated_charging_port_mode_in,
    input wire logic dcp_attach_in,
    input wire logic sense_attach_in,
    input wire logic peak_limit_in,
    input wire logic load_limit_in,
    input wire logic short_gnd_in,
    input wire logic output_ov_in,
    input wire logic temp_over_165_in,
    input wire logic clear_flags_in,
    input wire logic forced_pwm_out,
    input wire logic dither_en_out,
    input wire logic high_side_en_out,
    input wire logic converter_en_out,
    input wire logic fault_pin_out,
    input wire logic bus_current_limit_flag_out,
    input wire logic short_flag_out,
    input wire logic overvoltage_flag_out
);
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    AST_PWM_ATTACH: assert property (freq_lock_is_input_in && freq_lock_level_in
        && dedicated_charging_port_mode_in && !ext_clock_active_in
        |=> forced_pwm_out == $past(dcp_attach_in || sense_attach_in))
        else $error("forced pwm does not follow attach");
    AST_NO_DITHER_EXT: assert property (ext_clock_active_in |=> !dither_en_out)
        else $error("dither on with external clock");
    AST_HS_OFF: assert property (peak_limit_in || load_limit_in |=> !high_side_en_out)
        else $error("high side on during limit");
    AST_SHORT: assert property (short_gnd_in
        |=> fault_pin_out && short_flag_out && !converter_en_out)
        else $error("short not handled");
    AST_OVERVOLT: assert property (output_ov_in
        |=> fault_pin_out && overvoltage_flag_out && !converter_en_out)
        else $error("overvoltage not handled");
    AST_THERMAL: assert property (temp_over_165_in |-> ##2 !converter_en_out)
        else $error("converter on while overheated");
    AST_ILIM_HOLD: assert property (bus_current_limit_flag_out && !clear_flags_in
        |=> bus_current_limit_flag_out)
        else $error("limit flag dropped without clear");
    AST_SHORT_HOLD: assert property (short_flag_out && !clear_flags_in
        |=> $stable(short_flag_out))
        else $error("short flag dropped without clear");
endmodule : bfs_monitor

bind bfs_supervisor bfs_monitor u_bfs_monitor (.*);

/* File: testbench/bfs_load_model.sv */
/* Power stage and USB load seen by the supervisor.
 * Fault commands come from the bench; shares the system clock. */
`timescale 1ns/1ps
module bfs_load_model
(
    input wire logic sys_clk_in,
    input wire logic converter_en_in,
    input wire logic short_cmd_in,
    input wire logic ov_cmd_in,
    input wire logic load_cmd_in,
    output logic short_gnd_out,
    output logic output_ov_out,
    output logic load_limit_out,
    output logic output_uv_out,
    output logic switch_cycle_out
);
    logic [1:0] phase_q = 2'h0;
    always_ff @(posedge sys_clk_in)
    begin
        phase_q <= phase_q + 2'h1;
    end
    // Switching pulses only while the stage runs
    assign switch_cycle_out = converter_en_in && (phase_q == 2'h3);
    assign short_gnd_out = short_cmd_in;
    assign output_uv_out = short_cmd_in;
    assign output_ov_out = ov_cmd_in;
    assign load_limit_out = load_cmd_in;
endmodule : bfs_load_model

/* File: testbench/bfs_supervisor_tb.sv */
/* Self-checking bench for bfs_supervisor with a load model.
 * Short counts: ILIM_CYC 20, retry 30 cycles via port. */
`timescale 1ns/1ps
module bfs_supervisor_tb;
    import bfs_pkg::*;
    localparam int ILIM = 20;
    logic sys_clk_in = 0, rst_in = 1, startup_load_in = 0, serial_variant_in = 0;
    logic freq_lock_is_input_in = 0, freq_lock_level_in = 0, ext_clock_active_in = 0;
    logic dedicated_charging_port_mode_in = 0, dcp_attach_in = 0, sense_attach_in = 0;
    logic first_config_resistor_ss_in = 0, serial_ss_en_in = 0, serial_ss_en_wr_in = 0;
    logic [3:0] second_config_resistor_in = 4'h0;
    logic [2:0] third_config_resistor_in = 3'h0, serial_current_limit_select_in = 3'h0;
    logic [4:0] serial_gain_in = 5'h00;
    logic limit_reset_trip_select_in = 0, peak_limit_in = 0, output_below_2v_in = 0;
    logic [BFS_CNT_W-1:0] retry_cycles_in = 32'h0000001E;
    logic temp_over_165_in = 0, temp_below_155_in = 1, temp_over_140_in = 0;
    logic clear_flags_in = 0, short_c = 0, ov_c = 0, load_c = 0;
    logic load_limit_in, switch_cycle_in, output_uv_in, short_gnd_in, output_ov_in;
    logic forced_pwm_out, dither_en_out, high_side_en_out, converter_en_out;
    logic constant_current_out, fault_pin_out, bus_current_limit_flag_out;
    logic short_flag_out, overvoltage_flag_out, thermal_warning_flag_out;
    logic [2:0] current_limit_select_out;
    logic [4:0] cable_gain_out;
    int mismatches = 0, num_checks = 0, cycles = 0;
    int seed = 32'h63a58fbd;

    bfs_supervisor #(.ILIM_CYC(ILIM), .RETRY_CYC_DEFAULT(50)) u_bfs_supervisor (.*);
    bfs_load_model u_bfs_load_model (.sys_clk_in(sys_clk_in),
        .converter_en_in(converter_en_out), .short_cmd_in(short_c), .ov_cmd_in(ov_c),
        .load_cmd_in(load_c), .short_gnd_out(short_gnd_in), .output_ov_out(output_ov_in),
        .load_limit_out(load_limit_in), .output_uv_out(output_uv_in),
        .switch_cycle_out(switch_cycle_in));

    always #12.5 sys_clk_in = ~sys_clk_in;

    function automatic logic [4:0] gain_exp(input logic [2:0] t, input logic [3:0] s);
        return {t[2], s};
    endfunction : gain_exp

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    always @(posedge sys_clk_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask : cyc

    task automatic chk(input string nm, input logic [4:0] seen, input logic [4:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wait_en(input logic v);
        int i;
        for (i = 0; i < 60 && converter_en_out !== v; i++)
            cyc(1);
        chk("converter_en", converter_en_out, v);
    endtask : wait_en

    task automatic strobe_clear;
        clear_flags_in = 1;
        cyc(1);
        clear_flags_in = 0;
        cyc(1);
    endtask : strobe_clear

    initial
    begin
        cyc(20);
        chk("limit", current_limit_select_out, BFS_ILIM_RST);
        chk("pwm", forced_pwm_out, 5'h01);
        rst_in = 0;
        {freq_lock_is_input_in, freq_lock_level_in, dedicated_charging_port_mode_in} = 3'h7;
        repeat (12)
        begin
            {dcp_attach_in, sense_attach_in} = 2'($random(seed));
            cyc(1);
            chk("pwm", forced_pwm_out, dcp_attach_in | sense_attach_in);
        end
        {dcp_attach_in, sense_attach_in, dedicated_charging_port_mode_in} = 3'h0;
        cyc(1);
        chk("pwm", forced_pwm_out, 5'h01);
        first_config_resistor_ss_in = 1;
        repeat (4)
        begin
            {third_config_resistor_in, second_config_resistor_in} = 7'($random(seed));
            startup_load_in = 1;
            cyc(1);
            startup_load_in = 0;
            cyc(1);
            chk("dither", dither_en_out, 5'h01);
            chk("limit", current_limit_select_out,
                {1'b1, third_config_resistor_in[1:0]});
            chk("gain", cable_gain_out,
                gain_exp(third_config_resistor_in, second_config_resistor_in));
        end
        ext_clock_active_in = 1;
        cyc(1);
        chk("dither", dither_en_out, 5'h00);
        serial_variant_in = 1;
        {serial_current_limit_select_in, serial_gain_in} = 8'($random(seed));
        temp_over_140_in = 1;
        cyc(2);
        chk("limit", current_limit_select_out, serial_current_limit_select_in);
        chk("gain", cable_gain_out, serial_gain_in);
        chk("warn", thermal_warning_flag_out, 5'h01);
        load_c = 1;
        cyc(ILIM - 2);
        chk("ilim", bus_current_limit_flag_out, 5'h00);
        cyc(5);
        chk("ilim", bus_current_limit_flag_out & fault_pin_out, 5'h01);
        chk("cc", constant_current_out, 5'h01);
        chk("hs", high_side_en_out, 5'h00);
        load_c = 0;
        cyc(3);
        chk("ilim", bus_current_limit_flag_out, 5'h01);
        strobe_clear();
        chk("ilim", bus_current_limit_flag_out, 5'h00);
        short_c = 1;
        cyc(1);
        chk("short", {fault_pin_out, short_flag_out, converter_en_out}, 5'h06);
        short_c = 0;
        cyc(10);
        chk("retry", converter_en_out, 5'h00);
        wait_en(1);
        ov_c = 1;
        cyc(40);
        chk("ov", {fault_pin_out, overvoltage_flag_out, converter_en_out}, 5'h06);
        ov_c = 0;
        wait_en(1);
        {temp_over_165_in, temp_below_155_in} = 2'h2;
        cyc(1);
        temp_over_165_in = 0;
        cyc(40);
        chk("thermal", converter_en_out, 5'h00);
        temp_below_155_in = 1;
        wait_en(1);
        retry_cycles_in = '0;
        {peak_limit_in, output_below_2v_in} = 2'h3;
        wait_en(0);
        {peak_limit_in, output_below_2v_in} = 2'h0;
        wait_en(1);
        print_verdict();
    end
endmodule : bfs_supervisor_tb
